// ==== spmc_pkg.sv ====
// shared constants and carriers for the serial port mode control block
package spmc_pkg;

  // register byte addresses on the avalon slave
  localparam logic [17:0] SPMC_MODE_OFS = 18'h12004;
  localparam logic [17:0] SPMC_IRQ_STAT_OFS = 18'h12040;
  localparam logic [17:0] SPMC_IRQ_CLR_OFS = 18'h12044;
  localparam logic [17:0] SPMC_IRQ_EN_OFS = 18'h12048;

  // mode register field positions
  localparam int SPMC_LANE_HI = 31;
  localparam int SPMC_LANE_LO = 30;
  localparam int SPMC_IDLE_CHK_DIS_BIT = 29;
  localparam int SPMC_TX_BYPASS_BIT = 28;
  localparam int SPMC_ERR_WR_DIS_BIT = 27;
  localparam int SPMC_DEST_DIS_BIT = 26;
  localparam int SPMC_SELF_RST_BIT = 25;
  localparam int SPMC_MAINT_DIS_BIT = 24;
  localparam int SPMC_MLTC_EN_BIT = 5;
  localparam int SPMC_MLTC_FLAG_BIT = 4;
  localparam int SPMC_RST_EN_BIT = 3;
  localparam int SPMC_RST_FLAG_BIT = 2;
  localparam int SPMC_INBOUND_WRITE_IRQ_ENABLE_BIT = 1;
  localparam int SPMC_PW_FLAG_BIT = 0;

  // event index inside the status, clear and enable registers
  localparam int SPMC_EV_PW = 0;
  localparam int SPMC_EV_RST = 1;
  localparam int SPMC_EV_MLTC = 2;
  localparam int SPMC_EV_IDLE = 3;
  localparam int SPMC_EV_NUM = 4;

  // reset values
  localparam logic [1:0] SPMC_LANE_RST = 2'h0;
  localparam logic [SPMC_EV_NUM-1:0] SPMC_IRQ_EN_RST = 4'h0;

  // lane configuration codes
  localparam logic [1:0] SPMC_LANE_STD = 2'h0;
  localparam logic [1:0] SPMC_LANE_QUAD_1X = 2'h1;

  // reset control symbols needed in an unbroken run
  localparam int SPMC_RST_SEQ_LEN = 4;

  // transmit fifo depth when bypassed
  localparam int SPMC_BYPASS_DEPTH = 4;

  // class of a character seen during an idle sequence
  typedef enum logic [1:0] {
    SPMC_CHAR_K = 2'b00,
    SPMC_CHAR_A = 2'b01,
    SPMC_CHAR_R = 2'b10,
    SPMC_CHAR_OTHER = 2'b11
  } spmc_char_e;

  // control fields that steer the port
  typedef struct packed {
    logic [1:0] lane_config_select;
    logic idle_check_disable;
    logic tx_fifo_bypass;
    logic error_report_write_disable;
    logic dest_decode_disable;
    logic self_reset_enable;
    logic maint_id_check_disable;
  } spmc_ctrl_s;

  // received packet header
  typedef struct packed {
    logic valid;
    logic maint;
    logic [15:0] dest_id;
  } spmc_pkt_s;

endpackage : spmc_pkg

// ==== spmc_flag.sv ====
`timescale 1ns/1ps
// sticky event flags: a set in the same cycle as a clear wins
module spmc_flag #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // events and clears
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // stored flags
  output logic [WIDTH-1:0] flag_o
);

  // width must hold at least one flag
  if (WIDTH < 1) begin : g_chk
    $error("spmc_flag: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] flag; // stored flags
  logic [WIDTH-1:0] next_flag; // next flags

  // clear first, then let events win
  always_comb begin
    next_flag = (flag & ~clr_i) | set_i;
  end

  // register the flags
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end

  assign flag_o = flag;

endmodule : spmc_flag

// ==== spmc_rst_seq.sv ====
`timescale 1ns/1ps
// counts an unbroken run of reset control symbols
module spmc_rst_seq
  import spmc_pkg::*;
#(
  parameter int SEQ_LEN = SPMC_RST_SEQ_LEN
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // accepted control symbols
  input wire logic sym_valid_i,
  input wire logic sym_is_rst_i,
  // run complete, one cycle
  output logic seq_done_o
);

  // a run needs at least one symbol and fits the counter
  if (SEQ_LEN < 1 || SEQ_LEN > 255) begin : g_chk
    $error("spmc_rst_seq: SEQ_LEN out of range");
  end

  localparam logic [7:0] LAST = 8'(SEQ_LEN - 1);

  logic [7:0] cnt; // symbols seen in the run
  logic [7:0] next_cnt; // next count
  logic done; // registered completion pulse
  logic next_done; // next completion

  // any other symbol breaks the run; completion restarts it
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (sym_valid_i) begin
      if (!sym_is_rst_i) begin
        next_cnt = 8'h00;
      end else if (cnt == LAST) begin
        next_cnt = 8'h00;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  // register count and pulse
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 8'h00;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign seq_done_o = done;

endmodule : spmc_rst_seq

// ==== spmc_mode_ctrl.sv ====
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
// Operation
// - lane code 00 standard, 01 four 1x
// - idle check on: non K/A/R stops input
// - idle check off: ignore bad idle characters
// - bypass 0: transmit fifo runs normally
// - bypass 1: four-entry phase absorbing fifo
// - port-write error reports enabled unless disabled
// - decode on: foreign destination not forwarded
// - decode off: every destination forwarded
// - self reset off: four resets only interrupt
// - self reset on: reset serdes and registers
// - maint check on: mismatches go to mac
// - maint check off: handle all maintenance locally
// - bits 23 to 6 read zero
// - maint check reset value is parameter
// - multicast flag sticky, write one clears
// - reset-received flag sticky, write one clears
// - inbound write flag sticky, write one clears
module spmc_mode_ctrl
  import spmc_pkg::*;
#(
  parameter logic MAINT_DIS_RST = 1'b0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // idle sequence receiver
  input wire logic idle_char_valid_i,
  input wire spmc_char_e idle_char_i,
  input wire logic link_recover_i,
  output logic input_error_stop_o,
  // received packets
  input wire spmc_pkt_s pkt_i,
  input wire logic [15:0] base_id_i,
  output logic pkt_accept_o,
  output logic pkt_forward_o,
  output logic maint_to_mac_o,
  output logic maint_local_o,
  // control symbols and events
  input wire logic ctl_sym_valid_i,
  input wire logic ctl_sym_is_rst_i,
  input wire logic mltc_sym_i,
  input wire logic inbound_write_i,
  // control out to the port
  output spmc_ctrl_s ctrl_o,
  output logic [2:0] tx_fifo_depth_o,
  output logic error_report_enable_o,
  output logic serdes_reset_o,
  // interrupts
  output logic mltc_irq_o,
  output logic rst_irq_o,
  output logic inbound_write_irq_o,
  output logic irq_o
);

  // idle receiver states
  typedef enum logic [0:0] {
    SPMC_IDLE_RUN = 1'b0,
    SPMC_IDLE_STOP = 1'b1
  } spmc_idle_e;

  // byte-lane write mask from byte enables
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // bus handshake state
  logic ack, next_ack; // answer cycle marker
  logic [31:0] rdata, next_rdata; // registered read data
  logic req; // request pending
  logic wr_go; // write commits this edge
  logic [31:0] wmask; // active write bits
  // control and enable registers
  spmc_ctrl_s ctrl, next_ctrl; // stored control fields
  logic mltc_en, rst_en, inbound_write_irq_enable; // mode register line enables
  logic next_mltc_en, next_rst_en, next_inbound_write_irq_enable; // next line enables
  logic [SPMC_EV_NUM-1:0] irq_en, next_irq_en; // summary interrupt enables
  // events and flags
  logic [SPMC_EV_NUM-1:0] ev_set; // event pulses
  logic [SPMC_EV_NUM-1:0] ev_clr; // flag clears
  logic [SPMC_EV_NUM-1:0] flags; // sticky flags
  logic rst_seq_done; // four reset symbols seen
  logic self_rst, next_self_rst; // self reset pulse
  // idle receiver
  spmc_idle_e idle_st, next_idle_st; // receiver state
  logic bad_idle; // forbidden idle character
  // packet decode
  logic id_match; // destination equals base
  logic [3:0] pkt_out, next_pkt_out; // registered packet outputs

  assign req = avs_read | avs_write;
  assign wr_go = avs_write & ack;
  assign wmask = lane_mask(avs_byteenable);
  assign avs_waitrequest = req & ~ack;
  assign avs_readdata = rdata;

  // one wait cycle per access, read data captured before the answer
  always_comb begin
    next_ack = req & ~ack;
    next_rdata = rdata;
    if (avs_read && !ack) begin
      unique case (avs_address)
        SPMC_MODE_OFS: begin
          next_rdata = {ctrl, 18'h0_0000, mltc_en, flags[SPMC_EV_MLTC], rst_en, flags[SPMC_EV_RST],
                        inbound_write_irq_enable, flags[SPMC_EV_PW]};
        end
        SPMC_IRQ_STAT_OFS: begin
          next_rdata = {28'h000_0000, flags};
        end
        SPMC_IRQ_EN_OFS: begin
          next_rdata = {28'h000_0000, irq_en};
        end
        default: begin
          // clear register and unmapped space read zero
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // register bus answer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // control register writes, byte-lane masked
  always_comb begin
    next_ctrl = ctrl;
    next_mltc_en = mltc_en;
    next_rst_en = rst_en;
    next_inbound_write_irq_enable = inbound_write_irq_enable;
    next_irq_en = irq_en;
    if (self_rst) begin
      next_ctrl = '{lane_config_select: SPMC_LANE_RST, maint_id_check_disable: MAINT_DIS_RST, default: 1'b0};
      next_mltc_en = 1'b0;
      next_rst_en = 1'b0;
      next_inbound_write_irq_enable = 1'b0;
      next_irq_en = SPMC_IRQ_EN_RST;
    end else if (wr_go && avs_address == SPMC_MODE_OFS) begin
      if (wmask[SPMC_LANE_HI] &&
          (avs_writedata[SPMC_LANE_HI:SPMC_LANE_LO] == SPMC_LANE_STD ||
           avs_writedata[SPMC_LANE_HI:SPMC_LANE_LO] == SPMC_LANE_QUAD_1X)) begin
        next_ctrl.lane_config_select = avs_writedata[SPMC_LANE_HI:SPMC_LANE_LO];
      end
      if (wmask[SPMC_MAINT_DIS_BIT]) begin
        next_ctrl.idle_check_disable = avs_writedata[SPMC_IDLE_CHK_DIS_BIT];
        next_ctrl.tx_fifo_bypass = avs_writedata[SPMC_TX_BYPASS_BIT];
        next_ctrl.error_report_write_disable = avs_writedata[SPMC_ERR_WR_DIS_BIT];
        next_ctrl.dest_decode_disable = avs_writedata[SPMC_DEST_DIS_BIT];
        next_ctrl.self_reset_enable = avs_writedata[SPMC_SELF_RST_BIT];
        next_ctrl.maint_id_check_disable = avs_writedata[SPMC_MAINT_DIS_BIT];
      end
      if (wmask[SPMC_PW_FLAG_BIT]) begin
        next_mltc_en = avs_writedata[SPMC_MLTC_EN_BIT];
        next_rst_en = avs_writedata[SPMC_RST_EN_BIT];
        next_inbound_write_irq_enable = avs_writedata[SPMC_INBOUND_WRITE_IRQ_ENABLE_BIT];
      end
    end else if (wr_go && avs_address == SPMC_IRQ_EN_OFS && avs_byteenable[0]) begin
      next_irq_en = avs_writedata[SPMC_EV_NUM-1:0];
    end
  end

  // register control fields
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= '{lane_config_select: SPMC_LANE_RST, maint_id_check_disable: MAINT_DIS_RST, default: 1'b0};
      mltc_en <= 1'b0;
      rst_en <= 1'b0;
      inbound_write_irq_enable <= 1'b0;
      irq_en <= SPMC_IRQ_EN_RST;
    end else begin
      ctrl <= next_ctrl;
      mltc_en <= next_mltc_en;
      rst_en <= next_rst_en;
      inbound_write_irq_enable <= next_inbound_write_irq_enable;
      irq_en <= next_irq_en;
    end
  end

  // reset symbol run detector
  spmc_rst_seq #(
    .SEQ_LEN(SPMC_RST_SEQ_LEN)
  ) u_rst_seq (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sym_valid_i(ctl_sym_valid_i),
    .sym_is_rst_i(ctl_sym_is_rst_i),
    .seq_done_o(rst_seq_done)
  );

  // route the completed run to flag or self reset
  always_comb begin
    next_self_rst = rst_seq_done & ctrl.self_reset_enable;
    ev_set = '0;
    ev_set[SPMC_EV_RST] = rst_seq_done & ~ctrl.self_reset_enable;
    ev_set[SPMC_EV_MLTC] = mltc_sym_i;
    ev_set[SPMC_EV_PW] = inbound_write_i;
    ev_set[SPMC_EV_IDLE] = bad_idle;
  end

  // write-one clears from mode or clear register
  always_comb begin
    ev_clr = {SPMC_EV_NUM{self_rst}};
    if (wr_go && avs_address == SPMC_MODE_OFS && avs_byteenable[0]) begin
      ev_clr[SPMC_EV_RST] = ev_clr[SPMC_EV_RST] | avs_writedata[SPMC_RST_FLAG_BIT];
      ev_clr[SPMC_EV_MLTC] = ev_clr[SPMC_EV_MLTC] | avs_writedata[SPMC_MLTC_FLAG_BIT];
      ev_clr[SPMC_EV_PW] = ev_clr[SPMC_EV_PW] | avs_writedata[SPMC_PW_FLAG_BIT];
    end else if (wr_go && avs_address == SPMC_IRQ_CLR_OFS && avs_byteenable[0]) begin
      ev_clr = ev_clr | avs_writedata[SPMC_EV_NUM-1:0];
    end
  end

  // register self reset pulse
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      self_rst <= 1'b0;
    end else begin
      self_rst <= next_self_rst;
    end
  end

  // sticky flags, events win over clears
  spmc_flag #(
    .WIDTH(SPMC_EV_NUM)
  ) u_flags (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(ev_set),
    .clr_i(ev_clr),
    .flag_o(flags)
  );

  // idle receiver: stop on forbidden characters when checking
  always_comb begin
    bad_idle = (idle_st == SPMC_IDLE_RUN) && idle_char_valid_i &&
               (idle_char_i == SPMC_CHAR_OTHER) && !ctrl.idle_check_disable;
    next_idle_st = idle_st;
    unique case (idle_st)
      SPMC_IDLE_RUN: begin
        if (bad_idle) begin
          next_idle_st = SPMC_IDLE_STOP;
        end
      end
      SPMC_IDLE_STOP: begin
        if (link_recover_i || self_rst) begin
          next_idle_st = SPMC_IDLE_RUN;
        end
      end
    endcase
  end

  // register idle receiver state
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_st <= SPMC_IDLE_RUN;
    end else begin
      idle_st <= next_idle_st;
    end
  end

  // packet acceptance decode
  always_comb begin
    id_match = (pkt_i.dest_id == base_id_i);
    next_pkt_out = 4'h0;
    if (pkt_i.valid && pkt_i.maint) begin
      next_pkt_out[0] = 1'b1;
      next_pkt_out[2] = !id_match && !ctrl.maint_id_check_disable;
      next_pkt_out[3] = id_match || ctrl.maint_id_check_disable;
    end else if (pkt_i.valid) begin
      next_pkt_out[0] = 1'b1;
      next_pkt_out[1] = id_match || ctrl.dest_decode_disable;
    end
  end

  // register packet outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pkt_out <= 4'h0;
    end else begin
      pkt_out <= next_pkt_out;
    end
  end

  assign pkt_accept_o = pkt_out[0];
  assign pkt_forward_o = pkt_out[1];
  assign maint_to_mac_o = pkt_out[2];
  assign maint_local_o = pkt_out[3];
  assign input_error_stop_o = (idle_st == SPMC_IDLE_STOP);
  assign serdes_reset_o = self_rst;

  // control outputs to the port
  assign ctrl_o = ctrl;
  assign tx_fifo_depth_o = ctrl.tx_fifo_bypass ? 3'(SPMC_BYPASS_DEPTH) : 3'h0;
  assign error_report_enable_o = ~ctrl.error_report_write_disable;

  // interrupt lines
  assign mltc_irq_o = flags[SPMC_EV_MLTC] & mltc_en;
  assign rst_irq_o = flags[SPMC_EV_RST] & rst_en;
  assign inbound_write_irq_o = flags[SPMC_EV_PW] & inbound_write_irq_enable;
  assign irq_o = |(flags & irq_en);

endmodule : spmc_mode_ctrl

// ==== spmc_assertions.sv ====
`timescale 1ns/1ps
// port-level checker for the mode control block
module spmc_assertions
  import spmc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // receiver and packets
  input wire logic idle_char_valid_i,
  input wire spmc_char_e idle_char_i,
  input wire logic link_recover_i,
  input wire logic input_error_stop_o,
  input wire spmc_pkt_s pkt_i,
  input wire logic [15:0] base_id_i,
  input wire logic pkt_accept_o,
  input wire logic pkt_forward_o,
  input wire logic maint_to_mac_o,
  input wire logic maint_local_o,
  // symbols and control
  input wire logic ctl_sym_valid_i,
  input wire logic ctl_sym_is_rst_i,
  input wire spmc_ctrl_s ctrl_o,
  input wire logic [2:0] tx_fifo_depth_o,
  input wire logic error_report_enable_o,
  input wire logic serdes_reset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // forwarding expected for a plain packet
  logic fwd_exp;
  assign fwd_exp = ctrl_o.dest_decode_disable || (pkt_i.dest_id == base_id_i);
  // maintenance packet that goes to the mac
  logic mac_exp;
  assign mac_exp = !ctrl_o.maint_id_check_disable && (pkt_i.dest_id != base_id_i);
  // four reset symbols back to back, self reset off or on
  sequence s_run_plain;
    (ctl_sym_valid_i && ctl_sym_is_rst_i && !ctrl_o.self_reset_enable)[*4];
  endsequence
  sequence s_run_self;
    (ctl_sym_valid_i && ctl_sym_is_rst_i && ctrl_o.self_reset_enable)[*4];
  endsequence
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_lane_legal: assert property (ctrl_o.lane_config_select[1] == 1'b0)
    else $error("reserved lane code stored");
  a_reserved_zero: assert property (avs_read && !avs_waitrequest && avs_address == SPMC_MODE_OFS
    |-> avs_readdata[23:6] == 18'h0) else $error("reserved mode bits not zero");
  a_depth_bypass: assert property (tx_fifo_depth_o == (ctrl_o.tx_fifo_bypass ? 3'h4 : 3'h0))
    else $error("fifo depth wrong");
  a_err_report: assert property (error_report_enable_o == !ctrl_o.error_report_write_disable)
    else $error("error report enable wrong");
  a_pkt_forward: assert property (pkt_i.valid && !pkt_i.maint
    |=> pkt_accept_o && pkt_forward_o == $past(fwd_exp)) else $error("packet forwarding wrong");
  a_maint_mac: assert property (pkt_i.valid && pkt_i.maint && mac_exp |=> maint_to_mac_o && !maint_local_o)
    else $error("maintenance packet not sent to mac");
  a_maint_local: assert property (pkt_i.valid && pkt_i.maint && !mac_exp |=> maint_local_o && !maint_to_mac_o)
    else $error("maintenance packet not handled locally");
  a_idle_stop: assert property (idle_char_valid_i && idle_char_i == SPMC_CHAR_OTHER
    && !ctrl_o.idle_check_disable && !link_recover_i && !serdes_reset_o |=> input_error_stop_o)
    else $error("bad idle character not stopping input");
  a_idle_ignore: assert property (ctrl_o.idle_check_disable && !input_error_stop_o |=> !input_error_stop_o)
    else $error("idle error raised while checking off");
  a_rst_only_irq: assert property (s_run_plain |-> ##2 !serdes_reset_o)
    else $error("port reset without self reset");
  a_self_reset: assert property (ctl_sym_valid_i && !ctl_sym_is_rst_i ##1 s_run_self |-> ##2 serdes_reset_o)
    else $error("self reset pulse missing");
endmodule : spmc_assertions

bind spmc_mode_ctrl spmc_assertions i_chk (.core_clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .idle_char_valid_i, .idle_char_i, .link_recover_i, .input_error_stop_o,
  .pkt_i, .base_id_i, .pkt_accept_o, .pkt_forward_o, .maint_to_mac_o, .maint_local_o, .ctl_sym_valid_i,
  .ctl_sym_is_rst_i, .ctrl_o, .tx_fifo_depth_o, .error_report_enable_o, .serdes_reset_o);

// ==== spmc_link_partner.sv ====
`timescale 1ns/1ps
// link partner: one item per clock, fields scrambled outside valid cycles
module spmc_link_partner
  import spmc_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // items toward the port
  output logic idle_char_valid_o,
  output spmc_char_e idle_char_o,
  output spmc_pkt_s pkt_o,
  output logic ctl_sym_valid_o,
  output logic ctl_sym_is_rst_o,
  output logic mltc_sym_o,
  output logic inbound_write_o
);
  // quiet line at time zero
  initial begin
    idle_char_valid_o = 1'b0;
    idle_char_o = SPMC_CHAR_K;
    pkt_o = '0;
    ctl_sym_valid_o = 1'b0;
    ctl_sym_is_rst_o = 1'b0;
    mltc_sym_o = 1'b0;
    inbound_write_o = 1'b0;
  end
  // kind 0 quiet, 1 idle char, 2 control symbol, 3 packet, 4 multicast, 5 inbound write
  task drive(input int kind, input logic [17:0] arg);
    @(posedge core_clk_i);
    idle_char_valid_o <= (kind == 1);
    idle_char_o <= (kind == 1) ? spmc_char_e'(arg[1:0]) : spmc_char_e'(~idle_char_o);
    ctl_sym_valid_o <= (kind == 2);
    ctl_sym_is_rst_o <= (kind == 2) ? arg[0] : ~ctl_sym_is_rst_o;
    pkt_o <= (kind == 3) ? {1'b1, arg[16], arg[15:0]} : {1'b0, ~pkt_o.maint, ~pkt_o.dest_id};
    mltc_sym_o <= (kind == 4);
    inbound_write_o <= (kind == 5);
  endtask : drive
endmodule : spmc_link_partner

// ==== test_serial_port_mode_control.sv ====
`timescale 1ns/1ps
// self-checking bench for the mode control block
module test_serial_port_mode_control
  import spmc_pkg::*;
;
  logic core_clk_i, rst_n_i, avs_read, avs_write, avs_waitrequest, link_recover_i;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_data, wd;
  logic [3:0] avs_byteenable;
  logic [15:0] base_id_i, seed, dest;
  logic [1:0] lane;
  logic idle_char_valid_i, ctl_sym_valid_i, ctl_sym_is_rst_i, mltc_sym_i, inbound_write_i, mt;
  logic input_error_stop_o, pkt_accept_o, pkt_forward_o, maint_to_mac_o, maint_local_o;
  logic error_report_enable_o, serdes_reset_o, mltc_irq_o, rst_irq_o, inbound_write_irq_o, irq_o;
  logic [2:0] tx_fifo_depth_o;
  spmc_char_e idle_char_i;
  spmc_pkt_s pkt_i;
  spmc_ctrl_s ctrl_o;
  int n_errors = 0, check_count = 0, n_serdes = 0;
  spmc_mode_ctrl i_dut (.core_clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .idle_char_valid_i, .idle_char_i, .link_recover_i,
    .input_error_stop_o, .pkt_i, .base_id_i, .pkt_accept_o, .pkt_forward_o, .maint_to_mac_o, .maint_local_o,
    .ctl_sym_valid_i, .ctl_sym_is_rst_i, .mltc_sym_i, .inbound_write_i, .ctrl_o, .tx_fifo_depth_o,
    .error_report_enable_o, .serdes_reset_o, .mltc_irq_o, .rst_irq_o, .inbound_write_irq_o, .irq_o);
  spmc_link_partner i_lp (.core_clk_i, .idle_char_valid_o(idle_char_valid_i), .idle_char_o(idle_char_i),
    .pkt_o(pkt_i), .ctl_sym_valid_o(ctl_sym_valid_i), .ctl_sym_is_rst_o(ctl_sym_is_rst_i),
    .mltc_sym_o(mltc_sym_i), .inbound_write_o(inbound_write_i));
  // clock at 20 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // count self reset pulses
  always @(posedge core_clk_i) if (serdes_reset_o === 1'b1) n_serdes <= n_serdes + 1;
  // pseudo random step
  function logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  // mode register readback with no flag set
  function logic [31:0] mode_exp(input logic [1:0] l, input logic [31:0] d);
    mode_exp = {l, d[29:24], 18'h0, d[5], 1'b0, d[3], 1'b0, d[1], 1'b0};
  endfunction : mode_exp
  // {accept, forward} of a plain packet, {mac, local} of a maintenance one
  function logic [1:0] pkt_exp(input logic m, input logic [15:0] d, input logic [1:0] dis);
    if (m) pkt_exp = (!dis[0] && d != base_id_i) ? 2'b10 : 2'b01;
    else pkt_exp = {1'b1, dis[1] || d == base_id_i};
  endfunction : pkt_exp
  // compare and count
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is low at a rising edge
  task bus(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    @(posedge core_clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    rd_data = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // let the write settle before the caller looks
    @(negedge core_clk_i);
  endtask : bus
  // quiet link cycles, then look between edges
  task quiet(input int n);
    repeat (n) i_lp.drive(0, 18'h0);
    @(negedge core_clk_i);
  endtask : quiet
  // verdict
  task complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_errors++;
    complete_run;
  end
  initial begin
    rst_n_i = 1'b0;
    {avs_read, avs_write, link_recover_i} = 3'h0;
    avs_address = 18'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    seed = 16'h20F7;
    base_id_i = seed;
    lane = 2'h0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    bus(0, SPMC_MODE_OFS, 0); check("mode_reset", rd_data, 32'h0);
    bus(0, SPMC_IRQ_EN_OFS, 0); check("enable_reset", rd_data, 32'h0);
    // every lane code with random fields, self reset kept off
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wd = {i[1:0], seed[13:0], seed} & 32'hFDFF_FFFF;
      bus(1, SPMC_MODE_OFS, wd);
      if (!i[1]) lane = i[1:0];
      bus(0, SPMC_MODE_OFS, 0); check("mode_rw", rd_data, mode_exp(lane, wd));
      check("fifo_depth", tx_fifo_depth_o, wd[28] ? 32'h4 : 32'h0);
      check("err_report", error_report_enable_o, !wd[27]);
    end
    // upper byte masked off, low byte clears the enables
    bus(1, SPMC_MODE_OFS, 32'h3F00_0000, 4'h1);
    bus(0, SPMC_MODE_OFS, 0); check("byte_mask", rd_data, mode_exp(lane, wd & 32'hFFFF_FFC0));
    bus(1, 18'h12008, 32'hFFFF_FFFF);
    bus(0, 18'h12008, 0); check("unmapped", rd_data, 32'h0);
    // random packets under each decode setting
    for (int m = 0; m < 4; m++) begin
      bus(1, SPMC_MODE_OFS, {5'h0, m[1], 1'b0, m[0], 24'h0});
      repeat (6) begin
        seed = lfsr(seed);
        dest = seed[0] ? base_id_i : lfsr(seed);
        mt = seed[1];
        i_lp.drive(3, {1'b0, mt, dest});
        quiet(1);
        check("pkt_route", mt ? {maint_to_mac_o, maint_local_o} : {pkt_accept_o, pkt_forward_o},
          pkt_exp(mt, dest, m[1:0]));
      end
    end
    // idle checking on: K, A, R pass, other stops
    bus(1, SPMC_IRQ_EN_OFS, 32'hF);
    bus(1, SPMC_MODE_OFS, 32'h0);
    for (int c = 0; c < 4; c++) begin
      i_lp.drive(1, c);
      quiet(1);
      check("idle_stop", input_error_stop_o, c == 3);
    end
    check("irq_idle", irq_o, 1'b1);
    bus(0, SPMC_IRQ_STAT_OFS, 0); check("stat_idle", rd_data, 32'h8);
    @(posedge core_clk_i) link_recover_i <= 1'b1;
    @(posedge core_clk_i) link_recover_i <= 1'b0;
    bus(1, SPMC_IRQ_CLR_OFS, 32'hF);
    bus(1, SPMC_MODE_OFS, 32'h2000_0000);
    i_lp.drive(1, 3);
    quiet(1);
    check("idle_ignore", input_error_stop_o, 1'b0);
    bus(0, SPMC_IRQ_STAT_OFS, 0); check("stat_clear", rd_data, 32'h0);
    // multicast masked, unmasked, cleared
    bus(1, SPMC_IRQ_EN_OFS, 32'h0);
    i_lp.drive(4, 0);
    quiet(1);
    check("irq_masked", irq_o, 1'b0);
    bus(0, SPMC_IRQ_STAT_OFS, 0); check("stat_mltc", rd_data, 32'h4);
    bus(1, SPMC_IRQ_EN_OFS, 32'h4); check("irq_on", irq_o, 1'b1);
    bus(1, SPMC_IRQ_CLR_OFS, 32'h4); check("irq_off", irq_o, 1'b0);
    // mode register enables and write one to clear
    bus(1, SPMC_MODE_OFS, 32'h22);
    i_lp.drive(4, 0);
    i_lp.drive(5, 0);
    quiet(1);
    check("mltc_irq", mltc_irq_o, 1'b1);
    check("inbound_write_flag", inbound_write_irq_o, 1'b1);
    bus(0, SPMC_MODE_OFS, 0); check("mode_flags", rd_data, 32'h33);
    bus(1, SPMC_MODE_OFS, 32'h23);
    bus(0, SPMC_MODE_OFS, 0); check("pw_clear", rd_data, 32'h32);
    // broken run, then full run without self reset
    bus(1, SPMC_MODE_OFS, 32'h8);
    for (int k = 0; k < 8; k++) i_lp.drive(2, (k != 3));
    quiet(3);
    check("rst_irq", rst_irq_o, 1'b1);
    check("no_serdes", n_serdes, 0);
    bus(1, SPMC_MODE_OFS, 32'h0C); check("rst_clear", rst_irq_o, 1'b0);
    // self reset restores defaults
    bus(1, SPMC_IRQ_EN_OFS, 32'hF);
    bus(1, SPMC_MODE_OFS, 32'h0200_0008);
    for (int k = 0; k < 5; k++) i_lp.drive(2, k > 0);
    quiet(3);
    check("serdes", n_serdes, 1);
    bus(0, SPMC_MODE_OFS, 0); check("mode_dflt", rd_data, 32'h0);
    bus(0, SPMC_IRQ_EN_OFS, 0); check("en_dflt", rd_data, 32'h0);
    complete_run;
  end
endmodule : test_serial_port_mode_control
